/* File: src/cpuex_pkg.sv */
// Constants and types shared by the processor execution unit
package cpuex_pkg;
	// ****************************************
	// Widths, sizes and reset values
	// ****************************************
	localparam int DATA_W = 24;
	localparam int PC_W = 12;
	localparam int CORE_OPS = 94;
	localparam int STACK_DEPTH = 4;
	localparam logic [11:0] PC_RESET = 12'h000;
	localparam logic [23:0] ACC_RESET = 24'h000000;
	localparam logic [1:0] ACC_PTR = 2'h3;
	localparam logic [4:0] BIT_MAX = 5'h17;

	// ****************************************
	// Opcode groups, upper nibble of the first byte; subcodes and conditions, lower nibble
	// ****************************************
	localparam logic [3:0] GRP_CMP = 4'hf, GRP_SHORT = 4'he, GRP_TWO = 4'hd, GRP_CONST = 4'hc;
	localparam logic [3:0] GRP_SUB = 4'ha, GRP_JABS = 4'h9, GRP_JREL = 4'h8, GRP_SKIP = 4'h7;
	localparam logic [1:0] SH_CLEAR = 2'h0, SH_DECR = 2'h1, SH_GETFLAG = 2'h2, SH_MISC = 2'h3;
	localparam logic [1:0] MISC_CO_RESET = 2'h0, MISC_DEC_PTR = 2'h1, MISC_WDT = 2'h2;
	localparam logic [3:0] TW_ABS = 4'h0, TW_ADD = 4'h1, TW_AND = 4'h2, TW_BCLR = 4'h3, TW_BINV = 4'h4;
	localparam logic [3:0] TW_BSET = 4'h5, TW_NEG = 4'h6, TW_CLKSEL = 4'h7, TW_SEG = 4'h8;
	localparam logic [1:0] CN_ADD = 2'h0, CN_CMP = 2'h1, CN_AND = 2'h2;
	localparam logic [3:0] SUB_CALL = 4'h0, SUB_RET = 4'h1;
	localparam logic [3:0] COND_ALWAYS = 4'h0, COND_CARC = 4'h1, COND_CARS = 4'h2, COND_EQ = 4'h3;
	localparam logic [3:0] COND_NE = 4'h4, COND_NEG = 4'h5, COND_POS = 4'h6, COND_OVC = 4'h7, COND_OVS = 4'h8;

	// ****************************************
	// Byte lengths and cycle counts
	// ****************************************
	localparam logic [2:0] LEN_CMP_ACC = 3'h1, CYC_CMP_ACC = 3'h1;
	localparam logic [2:0] LEN_CLEAR = 3'h1, CYC_CLEAR = 3'h2;
	localparam logic [2:0] LEN_DECR = 3'h1, CYC_DECR = 3'h1;
	localparam logic [2:0] LEN_GETFLAG = 3'h1, CYC_GETFLAG = 3'h1;
	localparam logic [2:0] LEN_CO_RESET = 3'h1, CYC_CO_RESET = 3'h1;
	localparam logic [2:0] LEN_DEC_PTR = 3'h1, CYC_DEC_PTR = 3'h1;
	localparam logic [2:0] LEN_WDT = 3'h2, CYC_WDT = 3'h3;
	localparam logic [2:0] LEN_ABS = 3'h2, CYC_ABS = 3'h2;
	localparam logic [2:0] LEN_ADD_ACC = 3'h2, CYC_ADD_ACC = 3'h2;
	localparam logic [2:0] LEN_AND_ACC = 3'h2, CYC_AND_ACC = 3'h3;
	localparam logic [2:0] LEN_BIT = 3'h2, CYC_BIT = 3'h2;
	localparam logic [2:0] LEN_NEG = 3'h2, CYC_NEG = 3'h2;
	localparam logic [2:0] LEN_CLKSEL = 3'h2, CYC_CLKSEL = 3'h3;
	localparam logic [2:0] LEN_SEG = 3'h2, CYC_SEG = 3'h3;
	localparam logic [2:0] LEN_ADD_CONST = 3'h4, CYC_ADD_CONST = 3'h4;
	localparam logic [2:0] LEN_CMP_CONST = 3'h4, CYC_CMP_CONST = 3'h4;
	localparam logic [2:0] LEN_AND_CONST = 3'h5, CYC_AND_CONST = 3'h6;
	localparam logic [2:0] LEN_CALL = 3'h3, CYC_CALL = 3'h4;
	localparam logic [2:0] LEN_RET = 3'h1, CYC_RET = 3'h2;
	localparam logic [2:0] LEN_JABS = 3'h3, CYC_JABS = 3'h4;
	localparam logic [2:0] LEN_JREL = 3'h2, CYC_JREL = 3'h3;
	localparam logic [2:0] LEN_SKIP = 3'h2, CYC_SKIP = 3'h2;
	localparam logic [2:0] LEN_UNKNOWN = 3'h1, CYC_UNKNOWN = 3'h1;

	// ****************************************
	// Types
	// ****************************************
	typedef enum logic [3:0] {
		AOP_NONE = 4'b0000, AOP_ABS = 4'b0001, AOP_ADD = 4'b0010, AOP_AND = 4'b0011,
		AOP_BCLR = 4'b0100, AOP_BINV = 4'b0101, AOP_BSET = 4'b0110, AOP_NEG = 4'b0111,
		AOP_DECR = 4'b1000, AOP_CMP = 4'b1001, AOP_CLEAR = 4'b1010, AOP_FLAG = 4'b1011,
		AOP_SEG = 4'b1100
	} cpuex_aluop_t;
	typedef enum logic [2:0] {
		FL_NONE = 3'b000, FL_JABS = 3'b001, FL_JREL = 3'b010, FL_SKIP = 3'b011,
		FL_CALL = 3'b100, FL_RET = 3'b101
	} cpuex_flow_t;
	typedef enum logic [0:0] {ST_RUN = 1'b0, ST_SKIP = 1'b1} cpuex_state_t;
	typedef struct packed {
		logic known;
		logic [2:0] len;
		logic [2:0] cyc;
		cpuex_aluop_t aop;
		logic [1:0] dst;
		logic [1:0] srcb;
		logic use_const;
		cpuex_flow_t flow;
		logic [3:0] cond;
		logic co_reset;
		logic dec_ptr;
		logic wdt;
		logic clk_sel;
	} cpuex_dec_t;
endpackage

/* File: src/cpuex_alu_if.sv */
// Operand and result bundle between the core and its arithmetic unit
`timescale 1ns/1ps
`default_nettype none
interface cpuex_alu_if;
	cpuex_pkg::cpuex_aluop_t op;
	logic [23:0] a;
	logic [23:0] b;
	logic [4:0] bit_idx;
	logic [23:0] res;
	logic c;
	logic o;
	logic s;
	logic z;
	logic wr_res;
	logic upd_co;
	logic upd_sz;
	modport core(output op, a, b, bit_idx, input res, c, o, s, z, wr_res, upd_co, upd_sz);
	modport alu(input op, a, b, bit_idx, output res, c, o, s, z, wr_res, upd_co, upd_sz);
endinterface
`default_nettype wire

/* File: src/cpuex_alu.sv */
// Combinational arithmetic, logic and segment unit
`timescale 1ns/1ps
`default_nettype none
module cpuex_alu (
	cpuex_alu_if.alu bus
);
	logic [24:0] sum;
	logic [24:0] diff;
	logic [24:0] dec;
	logic [23:0] neg;
	logic [23:0] mask;
	logic [23:0] seg;
	logic min_neg;
	logic [23:0] val;
	logic c;
	logic o;
	logic wr;
	logic uco;
	logic usz;

	function automatic logic [6:0] seg_code(input logic [3:0] d);
		unique case (d)
			4'h0: return 7'h3f;
			4'h1: return 7'h06;
			4'h2: return 7'h5b;
			4'h3: return 7'h4f;
			4'h4: return 7'h66;
			4'h5: return 7'h6d;
			4'h6: return 7'h7d;
			4'h7: return 7'h07;
			4'h8: return 7'h7f;
			4'h9: return 7'h6f;
			default: return 7'h00;
		endcase
	endfunction

	assign sum = {1'b0, bus.a} + {1'b0, bus.b};
	assign diff = {1'b0, bus.b} - {1'b0, bus.a};
	assign dec = {1'b0, bus.a} - 25'h0000001;
	assign neg = ~bus.a + 24'h000001;
	assign mask = 24'h000001 << bus.bit_idx;
	assign min_neg = bus.a == 24'h800000;
	// Digits above nine give a blank pattern
	assign seg = (bus.a[23:4] == 20'h00000) ? {17'h00000, seg_code(bus.a[3:0])} : 24'h000000;

	always_comb begin
		val = bus.a;
		c = 1'b0;
		o = 1'b0;
		wr = 1'b1;
		uco = 1'b0;
		usz = 1'b1;
		unique case (bus.op)
			cpuex_pkg::AOP_ABS: begin
				val = bus.a[23] ? neg : bus.a;
				c = bus.a[23];
				o = min_neg;
				uco = 1'b1;
			end
			cpuex_pkg::AOP_ADD: begin
				val = sum[23:0];
				c = sum[24];
				o = (bus.a[23] == bus.b[23]) && (sum[23] != bus.a[23]);
				uco = 1'b1;
			end
			cpuex_pkg::AOP_AND: val = bus.a & bus.b;
			cpuex_pkg::AOP_BCLR: val = bus.a & ~mask;
			cpuex_pkg::AOP_BINV: val = bus.a ^ mask;
			cpuex_pkg::AOP_BSET: val = bus.a | mask;
			cpuex_pkg::AOP_NEG: val = neg;
			cpuex_pkg::AOP_DECR: begin
				val = dec[23:0];
				c = dec[24];
				o = min_neg;
				uco = 1'b1;
			end
			cpuex_pkg::AOP_CMP: begin
				val = diff[23:0];
				c = diff[24];
				o = (bus.b[23] != bus.a[23]) && (diff[23] != bus.b[23]);
				uco = 1'b1;
				wr = 1'b0;
			end
			cpuex_pkg::AOP_CLEAR: val = 24'h000000;
			cpuex_pkg::AOP_FLAG: wr = 1'b0;
			cpuex_pkg::AOP_SEG: begin
				val = seg;
				usz = 1'b0;
			end
			default: begin
				wr = 1'b0;
				usz = 1'b0;
			end
		endcase
	end

	assign bus.res = val;
	assign bus.c = c;
	assign bus.o = o;
	assign bus.s = val[23];
	assign bus.z = |val;
	assign bus.wr_res = wr;
	assign bus.upd_co = uco;
	assign bus.upd_sz = usz;
endmodule
`default_nettype wire

/* File: src/cpuex_retstack.sv */
// Return address stack for subroutine calls
`timescale 1ns/1ps
`default_nettype none
module cpuex_retstack #(
	parameter int DEPTH = cpuex_pkg::STACK_DEPTH,
	parameter int W = cpuex_pkg::PC_W
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic push,
	input wire logic pop,
	input wire logic [W-1:0] push_data,
	output logic [W-1:0] top
);
	localparam int PW = $clog2(DEPTH);
	logic [W-1:0] mem [DEPTH];
	logic [PW-1:0] sp;
	logic [PW-1:0] below_top;

	// Deeper nesting than DEPTH silently overwrites the oldest entry
	assign below_top = sp - PW'(2);

	always_ff @(posedge clk) begin
		if (push) begin
			mem[sp] <= push_data;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			sp <= '0;
			top <= '0;
		end else if (push) begin
			sp <= sp + PW'(1);
			top <= push_data;
		end else if (pop) begin
			sp <= sp - PW'(1);
			top <= mem[below_top];
		end
	end
endmodule
`default_nettype wire

/* File: src/cpuex_core.sv */
// Instruction fetch, decode and execution unit of the 24-bit processor
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - The full set has 94 core opcodes; codes not built here run as no-ops.
// - Absolute jumps load a 12-bit target anywhere in program space.
// - Relative jumps add a signed 8-bit displacement to the opcode address.
// - Skip passes up to three following opcodes when its condition holds.
// - Subroutine entry exists only as an unconditional absolute call.
// - Accumulators are 24 bits; arithmetic is two's complement.
// - Two-operand results go to the first accumulator, second stays unchanged.
// - The RAM pointer is the fourth accumulator, usable like the others.
// - Flags follow the last operation that affects them; others hold.
// - Magnitude: absolute value, updates all four flags, two bytes, two cycles.
// - Add accumulator or constant, all flags, two or four cycles.
// - AND accumulator or constant, sign and zero only, three or six cycles.
// - Bit clear, invert, set at index 0..23, sign and zero, two cycles.
// - Clear writes zero and updates sign and zero, one byte.
// - Clock select picks fast or slow clock, two bytes, three cycles.
// - Clock select operand one runs slow clock, zero turns it off.
// - Flag reset clears carry and overflow only, one byte one cycle.
// - Watchdog clear restarts the watchdog; software issues it before stop.
// - Compare forms second minus first, all flags, no register change.
// - Negate forms two's complement, sign and zero, two cycles.
// - Pointer decrement lowers the RAM pointer by one, no flags.
// - Digit to segment converts 0..9 to seven-segment code, three cycles.
// - Sign means negative, zero flag means nonzero; flag test keeps register.
module cpuex_core (
	input wire logic clk,
	input wire logic resetn,
	output logic [11:0] pm_addr,
	input wire logic [7:0] pm_data,
	output logic flag_carry,
	output logic flag_ovf,
	output logic flag_sign,
	output logic flag_nz,
	output logic [23:0] ram_ptr,
	output logic slow_clk_sel,
	output logic wdt_clear,
	output logic unknown_op
);
	// ****************************************
	// State
	// ****************************************
	cpuex_pkg::cpuex_state_t state;
	logic [11:0] pc;
	logic [11:0] inst_pc;
	logic [7:0] opcode;
	logic [31:0] ops;
	logic [2:0] cnt;
	logic [1:0] skip_left;
	logic fc;
	logic fo;
	logic fs;
	logic fz;
	logic [23:0] acc [4];

	cpuex_alu_if alu_bus ();

	// ****************************************
	// Decoder
	// ****************************************
	// One opcode byte per instruction; accumulator fields sit in its low bits or in the top bits of the first operand byte
	function automatic cpuex_pkg::cpuex_dec_t decode(input logic [7:0] op, input logic [31:0] ob);
		cpuex_pkg::cpuex_dec_t d;
		d = '0;
		d.len = cpuex_pkg::LEN_UNKNOWN;
		d.cyc = cpuex_pkg::CYC_UNKNOWN;
		d.aop = cpuex_pkg::AOP_NONE;
		d.flow = cpuex_pkg::FL_NONE;
		d.cond = op[3:0];
		unique case (op[7:4])
			cpuex_pkg::GRP_CMP: begin
				d.known = 1'b1;
				d.len = cpuex_pkg::LEN_CMP_ACC;
				d.cyc = cpuex_pkg::CYC_CMP_ACC;
				d.aop = cpuex_pkg::AOP_CMP;
				d.dst = op[3:2];
				d.srcb = op[1:0];
			end
			cpuex_pkg::GRP_SHORT: begin
				d.known = 1'b1;
				d.dst = op[1:0];
				unique case (op[3:2])
					cpuex_pkg::SH_CLEAR: begin
						d.len = cpuex_pkg::LEN_CLEAR;
						d.cyc = cpuex_pkg::CYC_CLEAR;
						d.aop = cpuex_pkg::AOP_CLEAR;
					end
					cpuex_pkg::SH_DECR: begin
						d.len = cpuex_pkg::LEN_DECR;
						d.cyc = cpuex_pkg::CYC_DECR;
						d.aop = cpuex_pkg::AOP_DECR;
					end
					cpuex_pkg::SH_GETFLAG: begin
						d.len = cpuex_pkg::LEN_GETFLAG;
						d.cyc = cpuex_pkg::CYC_GETFLAG;
						d.aop = cpuex_pkg::AOP_FLAG;
					end
					cpuex_pkg::SH_MISC: begin
						unique case (op[1:0])
							cpuex_pkg::MISC_CO_RESET: begin
								d.len = cpuex_pkg::LEN_CO_RESET;
								d.cyc = cpuex_pkg::CYC_CO_RESET;
								d.co_reset = 1'b1;
							end
							cpuex_pkg::MISC_DEC_PTR: begin
								d.len = cpuex_pkg::LEN_DEC_PTR;
								d.cyc = cpuex_pkg::CYC_DEC_PTR;
								d.dec_ptr = 1'b1;
							end
							cpuex_pkg::MISC_WDT: begin
								d.len = cpuex_pkg::LEN_WDT;
								d.cyc = cpuex_pkg::CYC_WDT;
								d.wdt = 1'b1;
							end
							default: d.known = 1'b0;
						endcase
					end
				endcase
			end
			cpuex_pkg::GRP_TWO: begin
				d.known = 1'b1;
				d.dst = ob[7:6];
				d.srcb = ob[5:4];
				d.len = cpuex_pkg::LEN_BIT;
				d.cyc = cpuex_pkg::CYC_BIT;
				unique case (op[3:0])
					cpuex_pkg::TW_ABS: begin
						d.len = cpuex_pkg::LEN_ABS;
						d.cyc = cpuex_pkg::CYC_ABS;
						d.aop = cpuex_pkg::AOP_ABS;
					end
					cpuex_pkg::TW_ADD: begin
						d.len = cpuex_pkg::LEN_ADD_ACC;
						d.cyc = cpuex_pkg::CYC_ADD_ACC;
						d.aop = cpuex_pkg::AOP_ADD;
					end
					cpuex_pkg::TW_AND: begin
						d.len = cpuex_pkg::LEN_AND_ACC;
						d.cyc = cpuex_pkg::CYC_AND_ACC;
						d.aop = cpuex_pkg::AOP_AND;
					end
					cpuex_pkg::TW_BCLR: d.aop = cpuex_pkg::AOP_BCLR;
					cpuex_pkg::TW_BINV: d.aop = cpuex_pkg::AOP_BINV;
					cpuex_pkg::TW_BSET: d.aop = cpuex_pkg::AOP_BSET;
					cpuex_pkg::TW_NEG: begin
						d.len = cpuex_pkg::LEN_NEG;
						d.cyc = cpuex_pkg::CYC_NEG;
						d.aop = cpuex_pkg::AOP_NEG;
					end
					cpuex_pkg::TW_CLKSEL: begin
						d.len = cpuex_pkg::LEN_CLKSEL;
						d.cyc = cpuex_pkg::CYC_CLKSEL;
						d.clk_sel = 1'b1;
					end
					cpuex_pkg::TW_SEG: begin
						d.len = cpuex_pkg::LEN_SEG;
						d.cyc = cpuex_pkg::CYC_SEG;
						d.aop = cpuex_pkg::AOP_SEG;
					end
					default: begin
						d.known = 1'b0;
						d.len = cpuex_pkg::LEN_UNKNOWN;
						d.cyc = cpuex_pkg::CYC_UNKNOWN;
					end
				endcase
			end
			cpuex_pkg::GRP_CONST: begin
				d.known = 1'b1;
				d.use_const = 1'b1;
				d.dst = op[1:0];
				unique case (op[3:2])
					cpuex_pkg::CN_ADD: begin
						d.len = cpuex_pkg::LEN_ADD_CONST;
						d.cyc = cpuex_pkg::CYC_ADD_CONST;
						d.aop = cpuex_pkg::AOP_ADD;
					end
					cpuex_pkg::CN_CMP: begin
						d.len = cpuex_pkg::LEN_CMP_CONST;
						d.cyc = cpuex_pkg::CYC_CMP_CONST;
						d.aop = cpuex_pkg::AOP_CMP;
					end
					cpuex_pkg::CN_AND: begin
						d.len = cpuex_pkg::LEN_AND_CONST;
						d.cyc = cpuex_pkg::CYC_AND_CONST;
						d.aop = cpuex_pkg::AOP_AND;
						d.dst = ob[31:30];
					end
					default: d.known = 1'b0;
				endcase
			end
			cpuex_pkg::GRP_SUB: begin
				d.known = (op[3:0] == cpuex_pkg::SUB_CALL) || (op[3:0] == cpuex_pkg::SUB_RET);
				d.cond = cpuex_pkg::COND_ALWAYS;
				if (op[3:0] == cpuex_pkg::SUB_CALL) begin
					d.len = cpuex_pkg::LEN_CALL;
					d.cyc = cpuex_pkg::CYC_CALL;
					d.flow = cpuex_pkg::FL_CALL;
				end else if (op[3:0] == cpuex_pkg::SUB_RET) begin
					d.len = cpuex_pkg::LEN_RET;
					d.cyc = cpuex_pkg::CYC_RET;
					d.flow = cpuex_pkg::FL_RET;
				end
			end
			cpuex_pkg::GRP_JABS, cpuex_pkg::GRP_JREL, cpuex_pkg::GRP_SKIP: begin
				d.known = op[3:0] <= cpuex_pkg::COND_OVS;
				if (!d.known) begin
				end else if (op[7:4] == cpuex_pkg::GRP_JABS) begin
					d.len = cpuex_pkg::LEN_JABS;
					d.cyc = cpuex_pkg::CYC_JABS;
					d.flow = cpuex_pkg::FL_JABS;
				end else if (op[7:4] == cpuex_pkg::GRP_JREL) begin
					d.len = cpuex_pkg::LEN_JREL;
					d.cyc = cpuex_pkg::CYC_JREL;
					d.flow = cpuex_pkg::FL_JREL;
				end else begin
					d.len = cpuex_pkg::LEN_SKIP;
					d.cyc = cpuex_pkg::CYC_SKIP;
					d.flow = cpuex_pkg::FL_SKIP;
				end
			end
			default: d.known = 1'b0;
		endcase
		return d;
	endfunction

	function automatic logic cond_met(input logic [3:0] cond, input logic c, input logic o, input logic s,
		input logic z);
		unique case (cond)
			cpuex_pkg::COND_ALWAYS: return 1'b1;
			cpuex_pkg::COND_CARC: return !c;
			cpuex_pkg::COND_CARS: return c;
			cpuex_pkg::COND_EQ: return !z;
			cpuex_pkg::COND_NE: return z;
			cpuex_pkg::COND_NEG: return s;
			cpuex_pkg::COND_POS: return !s;
			cpuex_pkg::COND_OVC: return !o;
			cpuex_pkg::COND_OVS: return o;
			default: return 1'b0;
		endcase
	endfunction

	// ****************************************
	// Fetch and decode wiring
	// ****************************************
	// The opcode is used straight from the program port in the first cycle
	wire first = (state == cpuex_pkg::ST_RUN) && (cnt == 3'h0);
	wire [7:0] cur_op = first ? pm_data : opcode;
	wire [31:0] pre_ops = first ? 32'h00000000 : ops;
	cpuex_pkg::cpuex_dec_t pre_dec;
	assign pre_dec = decode(cur_op, pre_ops);
	wire fetching = (state == cpuex_pkg::ST_RUN) && !first && (cnt < pre_dec.len);
	wire [31:0] cur_ops = fetching ? {ops[23:0], pm_data} : ops;
	cpuex_pkg::cpuex_dec_t dec;
	assign dec = decode(cur_op, cur_ops);
	wire last = (state == cpuex_pkg::ST_RUN) && (cnt == dec.cyc - 3'h1);
	wire exec = last && dec.known;
	wire taken = cond_met(dec.cond, fc, fo, fs, fz);
	wire [11:0] abs_target = cur_ops[11:0];
	wire [11:0] rel_target = inst_pc + {{4{cur_ops[7]}}, cur_ops[7:0]};
	cpuex_pkg::cpuex_dec_t skip_dec;
	assign skip_dec = decode(pm_data, 32'h00000000);
	wire [11:0] skip_next = pc + {9'h000, skip_dec.len};
	wire do_call = exec && (dec.flow == cpuex_pkg::FL_CALL);
	wire do_ret = exec && (dec.flow == cpuex_pkg::FL_RET);
	wire [11:0] ret_addr;

	// ****************************************
	// Arithmetic unit and return stack
	// ****************************************
	assign alu_bus.op = dec.known ? dec.aop : cpuex_pkg::AOP_NONE;
	assign alu_bus.a = acc[dec.dst];
	assign alu_bus.b = dec.use_const ? cur_ops[23:0] : acc[dec.srcb];
	assign alu_bus.bit_idx = cur_ops[4:0];

	cpuex_alu u_alu (
		.bus(alu_bus)
	);

	cpuex_retstack u_stack (
		.clk(clk),
		.resetn(resetn),
		.push(do_call),
		.pop(do_ret),
		.push_data(pc),
		.top(ret_addr)
	);

	// ****************************************
	// Accumulators x, y, z and RAM pointer
	// ****************************************
	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_acc
			logic [23:0] q;
			wire wr = exec && alu_bus.wr_res && (dec.dst == 2'(g));
			wire ptr_dec = exec && dec.dec_ptr && (2'(g) == cpuex_pkg::ACC_PTR);
			always_ff @(posedge clk) begin
				if (!resetn) begin
					q <= cpuex_pkg::ACC_RESET;
				end else if (wr) begin
					q <= alu_bus.res;
				end else if (ptr_dec) begin
					q <= q - 24'h000001;
				end
			end
			assign acc[g] = q;
		end
	endgenerate

	// ****************************************
	// Flags
	// ****************************************
	always_ff @(posedge clk) begin
		if (!resetn) begin
			fc <= 1'b0;
			fo <= 1'b0;
			fs <= 1'b0;
			fz <= 1'b0;
		end else if (exec) begin
			if (dec.co_reset) begin
				fc <= 1'b0;
				fo <= 1'b0;
			end else if (alu_bus.upd_co) begin
				fc <= alu_bus.c;
				fo <= alu_bus.o;
			end
			if (alu_bus.upd_sz) begin
				fs <= alu_bus.s;
				fz <= alu_bus.z;
			end
		end
	end

	// ****************************************
	// Sequencer
	// ****************************************
	always_ff @(posedge clk) begin
		if (!resetn) begin
			state <= cpuex_pkg::ST_RUN;
			pc <= cpuex_pkg::PC_RESET;
			inst_pc <= cpuex_pkg::PC_RESET;
			opcode <= 8'h00;
			ops <= 32'h00000000;
			cnt <= 3'h0;
			skip_left <= 2'h0;
		end else if (state == cpuex_pkg::ST_SKIP) begin
			// Each cycle steps over one whole opcode by its own length
			pc <= skip_next;
			skip_left <= skip_left - 2'h1;
			if (skip_left == 2'h1) begin
				state <= cpuex_pkg::ST_RUN;
			end
		end else begin
			if (first) begin
				opcode <= pm_data;
				inst_pc <= pc;
			end
			if (fetching) begin
				ops <= cur_ops;
			end
			cnt <= last ? 3'h0 : cnt + 3'h1;
			if (exec && dec.flow == cpuex_pkg::FL_JABS && taken) begin
				pc <= abs_target;
			end else if (exec && dec.flow == cpuex_pkg::FL_JREL && taken) begin
				pc <= rel_target;
			end else if (do_call) begin
				pc <= abs_target;
			end else if (do_ret) begin
				pc <= ret_addr;
			end else if (first || fetching) begin
				pc <= pc + 12'h001;
			end
			if (exec && dec.flow == cpuex_pkg::FL_SKIP && taken && cur_ops[1:0] != 2'h0) begin
				state <= cpuex_pkg::ST_SKIP;
				skip_left <= cur_ops[1:0];
			end
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	always_ff @(posedge clk) begin
		if (!resetn) begin
			slow_clk_sel <= 1'b0;
			wdt_clear <= 1'b0;
			unknown_op <= 1'b0;
		end else begin
			if (exec && dec.clk_sel) begin
				slow_clk_sel <= cur_ops[0];
			end
			wdt_clear <= exec && dec.wdt;
			unknown_op <= last && !dec.known;
		end
	end

	assign pm_addr = pc;
	assign flag_carry = fc;
	assign flag_ovf = fo;
	assign flag_sign = fs;
	assign flag_nz = fz;
	assign ram_ptr = acc[cpuex_pkg::ACC_PTR];
endmodule
`default_nettype wire

/* File: dv/cpuex_rom.sv */
// Asynchronous-read program memory beside the execution unit
`timescale 1ns/1ps
`default_nettype none
module cpuex_rom (
	input wire logic [11:0] addr,
	output logic [7:0] data
);
	logic [7:0] mem [4096];
	// Unloaded bytes read as an unbuilt code, so a stray fetch shows
	initial begin
		foreach (mem[i]) mem[i] = 8'hef;
	end
	// Constants are stored most significant byte first
	assign data = mem[addr];
endmodule
`default_nettype wire

/* File: dv/cpuex_core_assertions.sv */
// Port-level checks of the processor execution unit
`timescale 1ns/1ps
`default_nettype none
module cpuex_core_assertions (
	input wire logic clk,
	input wire logic resetn,
	input wire logic [11:0] pm_addr,
	input wire logic [7:0] pm_data,
	input wire logic flag_carry,
	input wire logic flag_ovf,
	input wire logic flag_sign,
	input wire logic flag_nz,
	input wire logic [23:0] ram_ptr,
	input wire logic slow_clk_sel,
	input wire logic wdt_clear,
	input wire logic unknown_op
);
	chk_pc_reset: assert property (@(posedge clk) !resetn |=> pm_addr == 12'h000)
		else $error("pc not cleared");
	chk_out_reset: assert property (@(posedge clk) !resetn |=>
		{flag_carry, flag_ovf, flag_sign, flag_nz, slow_clk_sel, ram_ptr} == 29'h0) else $error("outputs not cleared");
	chk_wdt_pulse: assert property (@(posedge clk) disable iff (!resetn) wdt_clear |=> !wdt_clear)
		else $error("watchdog pulse too long");
	chk_pulse_apart: assert property (@(posedge clk) disable iff (!resetn) wdt_clear |-> !unknown_op)
		else $error("watchdog and unknown together");
	chk_clk_quiet: assert property (@(posedge clk) disable iff (!resetn) $changed(slow_clk_sel) |->
		$stable({flag_carry, flag_ovf, flag_sign, flag_nz}) && $stable(ram_ptr)) else $error("clock select side effect");
	chk_ptr_quiet: assert property (@(posedge clk) disable iff (!resetn)
		$changed(ram_ptr) |-> $stable(slow_clk_sel)) else $error("pointer change moved clock");
	// An idle cycle never follows another, so the pc always moves again
	chk_pc_moves: assert property (@(posedge clk) disable iff (!resetn)
		$past(resetn) && $stable(pm_addr) |=> !$stable(pm_addr)) else $error("pc stalled");
	chk_unknown_quiet: assert property (@(posedge clk) disable iff (!resetn) unknown_op |->
		$stable({flag_carry, flag_ovf, flag_sign, flag_nz, slow_clk_sel, ram_ptr})) else $error("unknown op had effect");
endmodule
bind cpuex_core cpuex_core_assertions cpuex_core_assertions_inst (.clk(clk), .resetn(resetn), .pm_addr(pm_addr),
	.pm_data(pm_data), .flag_carry(flag_carry), .flag_ovf(flag_ovf), .flag_sign(flag_sign), .flag_nz(flag_nz),
	.ram_ptr(ram_ptr), .slow_clk_sel(slow_clk_sel), .wdt_clear(wdt_clear), .unknown_op(unknown_op));
`default_nettype wire

/* File: dv/cpuex_core_tb.sv */
// Self-checking bench of the processor execution unit
`timescale 1ns/1ps
`default_nettype none
module cpuex_core_tb;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic [11:0] pm_addr;
	logic [7:0] pm_data;
	logic flag_carry, flag_ovf, flag_sign, flag_nz, slow_clk_sel, wdt_clear, unknown_op;
	logic [23:0] ram_ptr, k, m;
	int miscompares = 0;
	int n_compared = 0;
	int cycles = 0;
	int n_wdt = 0;
	int n_unk = 0;
	always #10 clk = ~clk;
	cpuex_core cpuex_core_inst (.clk(clk), .resetn(resetn), .pm_addr(pm_addr), .pm_data(pm_data),
		.flag_carry(flag_carry), .flag_ovf(flag_ovf), .flag_sign(flag_sign), .flag_nz(flag_nz),
		.ram_ptr(ram_ptr), .slow_clk_sel(slow_clk_sel), .wdt_clear(wdt_clear), .unknown_op(unknown_op));
	cpuex_rom cpuex_rom_inst (.addr(pm_addr), .data(pm_data));
	task conclude();
		$display("miscompares %0d of %0d compared", miscompares, n_compared);
		if (miscompares == 0 && n_compared > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task chk(input logic [23:0] seen, input logic [23:0] exp);
		n_compared++;
		if (seen !== exp) begin
			miscompares++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// Pulses counted outside reset only; a spin loop keeps them to one each
	always @(posedge clk) begin
		cycles++;
		if (resetn && wdt_clear === 1'b1) n_wdt++;
		if (resetn && unknown_op === 1'b1) n_unk++;
		if (cycles == 1000) begin
			miscompares++;
			conclude();
		end
	end
	// Clear, add, compare, flag reset, decrement, clock select, watchdog, unknown, spin
	task run(input logic s);
		logic [7:0] p [19];
		logic [23:0] d;
		d = m - k;
		p = '{8'he3, 8'hc3, k[23:16], k[15:8], k[7:0], 8'hc7, m[23:16], m[15:8], m[7:0], 8'hec, 8'hed,
			8'hd7, {7'h00, s}, 8'hee, 8'h00, 8'hef, 8'h90, 8'h00, 8'h10};
		@(posedge clk);
		resetn <= 1'b0;
		foreach (p[j]) cpuex_rom_inst.mem[j] <= p[j];
		repeat (2) @(posedge clk);
		n_wdt = 0;
		n_unk = 0;
		resetn <= 1'b1;
		repeat (40) @(posedge clk);
		#1;
		chk(ram_ptr, k - 24'h1);
		chk({23'h0, flag_sign}, {23'h0, d[23]});
		chk({23'h0, flag_nz}, {23'h0, |d});
		chk({22'h0, flag_carry, flag_ovf}, 24'h0);
		chk({23'h0, slow_clk_sel}, {23'h0, s});
		chk(24'(n_wdt), 24'h1);
		chk(24'(n_unk), 24'h1);
		chk({14'h0, pm_addr[11:2]}, 24'h4);
	endtask
	initial begin
		k = 24'h0;
		m = 24'h0;
		void'($urandom(24342));
		for (int i = 0; i < 8; i++) begin
			k = (i == 0) ? 24'h000000 : (i == 1) ? 24'h800000 : (i == 2) ? 24'hffffff : 24'($urandom);
			m = (i == 1) ? k : 24'($urandom);
			run(i[0]);
		end
		conclude();
	end
endmodule
`default_nettype wire
